/* rtl/cbrs_sched.sv */
// bus request scheduler: priorities, write buffer, channel sequencing
`timescale 1ns/10ps
module cbrs_sched #(
	parameter int AW = cbrs_pkg::ADDR_W
) (
	// clock, reset, enable
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          ce_i,
	// execution unit data requests
	input  wire logic          exec_req_i,
	input  wire logic          exec_wr_i,
	input  wire logic          exec_lock_i,
	input  wire logic          exec_pre_i,
	input  wire logic [AW-1:0] exec_addr_i,
	input  wire logic [15:0]   exec_wdata_i,
	input  wire logic          exec_word_i,
	output logic               exec_ack_o,
	output logic               exec_stall_o,
	// instruction queue and control flow
	input  wire logic [2:0]    queue_free_i,
	input  wire logic          flow_stop_i,
	input  wire logic          jump_i,
	input  wire logic [AW-1:0] jump_addr_i,
	input  wire logic          prot_mode_i,
	input  wire logic [AW-1:0] seg_last_i,
	input  wire logic [AW-1:0] exec_ip_i,
	input  wire logic [AW-1:0] instr_end_i,
	output logic               gp_fault_o,
	output logic [7:0]         fault_vec_o,
	// coprocessor channel
	input  wire logic          coproc_xfer_request_i,
	input  wire logic          cp_to_mem_i,
	input  wire logic [AW-1:0] cp_addr_i,
	// external hold
	input  wire logic          hold_i,
	output logic               hold_ack_o,
	// local bus cycle start and end
	input  wire logic          bus_done_i,
	output logic               cyc_start_o,
	output logic [2:0]         cyc_kind_o,
	output logic [AW-1:0]      cyc_addr_o,
	output logic [15:0]        cyc_wdata_o,
	output logic               cyc_byte_o,
	output logic               cyc_lock_o
);
	localparam int NREQ = 7;

	cbrs_pkg::cbrs_state_t state_ff;
	logic [NREQ-1:0]       req;
	logic [NREQ-1:0]       gnt;
	logic                  wb_full_ff;
	logic [AW-1:0]         wb_addr_ff;
	logic [15:0]           wb_data_ff;
	logic                  wb_byte_ff;
	logic                  split_ff;
	logic [AW-1:0]         split_addr_ff;
	logic [1:0]            chan_left_ff;
	logic                  chan_odd_ff;
	logic [1:0]            inh_ff;
	logic                  pf_busy_ff;
	logic                  pf_stop_ff;
	logic                  boundary;
	logic [AW-1:0]         fetch_addr;
	logic                  fetch_byte;
	logic                  at_limit;
	logic                  pf_ok;
	logic                  exec_write_buf;
	logic                  exec_direct;

	initial begin
		if (AW < 2) $error("cbrs_sched address too narrow");
	end

	// =========================================================
	// request collection
	// =========================================================
	assign boundary = (state_ff == cbrs_pkg::CBRS_S_IDLE) || (state_ff == cbrs_pkg::CBRS_S_BUSY && bus_done_i && !split_ff && chan_left_ff == 2'h0);
	// an idle bus takes a write directly, so buffering never costs a clock
	assign exec_write_buf = exec_req_i && exec_wr_i && !exec_lock_i && !wb_full_ff
		&& !boundary;
	assign exec_direct    = exec_req_i && !exec_write_buf && !(exec_wr_i && wb_full_ff);

	// prefetch: queue room, not suppressed ahead of data, not stopped, not past limit
	assign pf_ok = (queue_free_i >= 3'(cbrs_pkg::PF_MIN_FREE))
		&& inh_ff == 2'h0 && !exec_pre_i
		&& !pf_stop_ff && !flow_stop_i
		&& !at_limit;

	always_comb begin
		req    = '0;
		req[0] = exec_direct && exec_lock_i;
		req[1] = 1'b0; // split halves run inside the busy state
		req[2] = hold_i;
		req[3] = coproc_xfer_request_i;
		req[4] = exec_direct && !exec_lock_i;
		req[5] = wb_full_ff;
		req[6] = pf_ok && !exec_req_i && !(|req[5:0]);
	end

	cbrs_prio #(
		.N (NREQ)
	) u_prio (
		.req_i (req),
		.gnt_o (gnt)
	);

	cbrs_fetch_limit #(
		.AW (AW)
	) u_fetch (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.ce_i         (ce_i),
		.jump_i       (jump_i),
		.jump_addr_i  (jump_addr_i),
		.prot_mode_i  (prot_mode_i),
		.seg_last_i   (seg_last_i),
		.fetch_done_i (pf_busy_ff && bus_done_i && ce_i),
		.fetch_addr_o (fetch_addr),
		.fetch_byte_o (fetch_byte),
		.at_limit_o   (at_limit)
	);

	// =========================================================
	// prefetch suppression and stop
	// =========================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			inh_ff <= 2'h0;
		end else if (ce_i) begin
			if (exec_pre_i) begin
				inh_ff <= 2'(cbrs_pkg::PF_INHIBIT);
			end else if (inh_ff != 2'h0) begin
				inh_ff <= inh_ff - 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pf_stop_ff <= 1'b0;
		end else if (ce_i) begin
			// a stop queued together with a jump wins
			if (flow_stop_i) begin
				pf_stop_ff <= 1'b1;
			end else if (jump_i) begin
				pf_stop_ff <= 1'b0;
			end
		end
	end

	// =========================================================
	// write buffer, single entry
	// =========================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_full_ff <= 1'b0;
			wb_addr_ff <= '0;
			wb_data_ff <= 16'h0000;
			wb_byte_ff <= 1'b0;
		end else if (ce_i) begin
			if (exec_write_buf) begin
				wb_full_ff <= 1'b1;
				wb_addr_ff <= exec_addr_i;
				wb_data_ff <= exec_wdata_i;
				wb_byte_ff <= !exec_word_i;
			end else if (boundary && gnt[5]) begin
				wb_full_ff <= 1'b0;
			end
		end
	end

	assign exec_stall_o = exec_req_i && exec_wr_i && wb_full_ff;
	assign exec_ack_o   = ce_i && (exec_write_buf || (boundary && (gnt[0] || gnt[4])));

	// =========================================================
	// bus cycle sequencer
	// =========================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff      <= cbrs_pkg::CBRS_S_IDLE;
			cyc_start_o   <= 1'b0;
			cyc_kind_o    <= 3'h0;
			cyc_addr_o    <= '0;
			cyc_wdata_o   <= 16'h0000;
			cyc_byte_o    <= 1'b0;
			cyc_lock_o    <= 1'b0;
			split_ff      <= 1'b0;
			split_addr_ff <= '0;
			chan_left_ff  <= 2'h0;
			chan_odd_ff   <= 1'b0;
			pf_busy_ff    <= 1'b0;
		end else if (ce_i) begin
			cyc_start_o <= 1'b0;
			case (state_ff)
				cbrs_pkg::CBRS_S_HOLD: begin
					if (!hold_i) begin
						state_ff <= cbrs_pkg::CBRS_S_IDLE;
					end
				end
				default: begin
					if (state_ff == cbrs_pkg::CBRS_S_BUSY && bus_done_i && split_ff) begin
						// second byte of an odd word, priority two
						split_ff    <= 1'b0;
						cyc_start_o <= 1'b1;
						cyc_addr_o  <= split_addr_ff;
						cyc_byte_o  <= 1'b1;
					end else if (state_ff == cbrs_pkg::CBRS_S_BUSY && bus_done_i
						&& chan_left_ff != 2'h0) begin
						// rest of channel word runs unbroken
						chan_left_ff <= chan_left_ff - 2'h1;
						cyc_start_o  <= 1'b1;
						if (cp_to_mem_i) begin
							cyc_kind_o <= 3'(cbrs_pkg::CBRS_K_WRITE);
							cyc_addr_o <= (chan_odd_ff && chan_left_ff == 2'h1)
								? cp_addr_i + AW'(1) : cp_addr_i;
							cyc_byte_o <= chan_odd_ff;
						end else if (chan_odd_ff && chan_left_ff == 2'h2) begin
							cyc_kind_o <= 3'(cbrs_pkg::CBRS_K_READ);
							cyc_addr_o <= cp_addr_i + AW'(1);
							cyc_byte_o <= 1'b1;
						end else begin
							cyc_kind_o <= 3'(cbrs_pkg::CBRS_K_CPWR);
							cyc_byte_o <= 1'b0;
						end
					end else if (boundary) begin
						pf_busy_ff  <= gnt[6];
						cyc_lock_o  <= gnt[0];
						cyc_start_o <= |gnt & !gnt[2];
						state_ff    <= cbrs_pkg::CBRS_S_BUSY;
						case (1'b1)
							gnt[0], gnt[4]: begin
								cyc_kind_o  <= exec_wr_i ? 3'(cbrs_pkg::CBRS_K_WRITE)
									: 3'(cbrs_pkg::CBRS_K_READ);
								cyc_addr_o  <= exec_addr_i;
								cyc_wdata_o <= exec_wdata_i;
								cyc_byte_o  <= !exec_word_i || exec_addr_i[0];
								split_ff    <= exec_word_i && exec_addr_i[0];
								split_addr_ff <= exec_addr_i + AW'(1);
							end
							gnt[2]: begin
								state_ff <= cbrs_pkg::CBRS_S_HOLD;
							end
							gnt[3]: begin
								// two cycles, three when memory side is odd
								chan_odd_ff  <= cp_addr_i[0];
								chan_left_ff <= cp_addr_i[0] ? 2'h2 : 2'h1;
								cyc_kind_o   <= cp_to_mem_i ? 3'(cbrs_pkg::CBRS_K_CPRD)
									: 3'(cbrs_pkg::CBRS_K_READ);
								cyc_addr_o   <= cp_addr_i;
								cyc_byte_o   <= cp_addr_i[0] && !cp_to_mem_i;
							end
							gnt[5]: begin
								cyc_kind_o  <= 3'(cbrs_pkg::CBRS_K_WRITE);
								cyc_addr_o  <= wb_addr_ff;
								cyc_wdata_o <= wb_data_ff;
								cyc_byte_o  <= wb_byte_ff || wb_addr_ff[0];
								split_ff    <= !wb_byte_ff && wb_addr_ff[0];
								split_addr_ff <= wb_addr_ff + AW'(1);
							end
							gnt[6]: begin
								cyc_kind_o <= 3'(cbrs_pkg::CBRS_K_FETCH);
								cyc_addr_o <= fetch_addr;
								cyc_byte_o <= fetch_byte;
							end
							default: begin
								state_ff <= cbrs_pkg::CBRS_S_IDLE;
							end
						endcase
					end
					// a prefetch in flight holds off everything until bus_done
				end
			endcase
		end
	end

	assign hold_ack_o = state_ff == cbrs_pkg::CBRS_S_HOLD;

	// =========================================================
	// code limit fault
	// =========================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gp_fault_o  <= 1'b0;
			fault_vec_o <= 8'h00;
		end else if (ce_i) begin
			// past last full instruction, including the padding byte
			gp_fault_o  <= prot_mode_i && (exec_ip_i > instr_end_i || exec_ip_i > seg_last_i);
			fault_vec_o <= cbrs_pkg::GP_FAULT_VEC;
		end
	end

	// =========================================================
	// checks
	// =========================================================
	lock_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && boundary && req[0] |=> cyc_lock_o && cyc_start_o)
		else $error("locked request lost to lower priority");
	split_second_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && state_ff == cbrs_pkg::CBRS_S_BUSY && bus_done_i && split_ff
		|=> cyc_start_o && cyc_byte_o && !split_ff)
		else $error("second byte not issued");
	hold_grant_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && boundary && hold_i && !req[0] |=> hold_ack_o)
		else $error("hold not granted");
	cp_over_exec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && boundary && req[3] && !(|req[2:0]) |=> !cyc_lock_o && chan_left_ff != 2'h0)
		else $error("channel lost to lower priority");
	exec_over_pf_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && boundary && req[4] && !(|req[3:0])
		|=> cyc_start_o && cyc_kind_o != 3'(cbrs_pkg::CBRS_K_FETCH))
		else $error("prefetch beat data");
	pf_inhibit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && exec_pre_i |=> !req[6] ##1 !req[6])
		else $error("prefetch within inhibit window");
	wb_stall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wb_full_ff && exec_req_i && exec_wr_i |-> exec_stall_o && !exec_ack_o)
		else $error("second write not stalled");
	pf_no_abort_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == cbrs_pkg::CBRS_S_BUSY && pf_busy_ff && !bus_done_i |=> !cyc_start_o)
		else $error("prefetch preempted");
	chan_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cyc_start_o && cyc_kind_o == 3'(cbrs_pkg::CBRS_K_CPWR) |-> !cyc_byte_o)
		else $error("byte channel transfer");
	fault_vec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		gp_fault_o |-> fault_vec_o == 8'h0d)
		else $error("wrong fault vector");

	pf_cycle_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		cyc_start_o && cyc_kind_o == 3'(cbrs_pkg::CBRS_K_FETCH));
	chan_odd_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		boundary && gnt[3] && cp_addr_i[0]);
	wb_stall_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) exec_stall_o);
	hold_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) hold_ack_o);
endmodule

/* rtl/cbrs_pkg.sv */
// package of constants and types for the cpu bus request scheduler
// Notes on behaviour
// - locked data transfers win over every other bus request (a locked write stalls behind a full write buffer until it drains)
// - second half of a split word or channel transfer ranks second
// - external bus-hold request ranks third
// - execution-unit data transfer ranks fifth, above prefetch
// - prefetch ranks lowest and runs only when nothing else is pending
// - prefetch starts are blocked two clocks before a data transfer
// - protected mode prefetch never faults and stops at last code word
// - executing past the last complete instruction raises fault 13
// - even last byte: full word fetched, extra byte executes as fault 13
// - prefetch may follow any bus cycle with no idle clocks
// - a started prefetch is never aborted by a data request
// - a write meeting a busy bus is held in a buffer, execution continues (locked writes are not buffered and wait for the bus)
// - only one write buffered; a second write stalls execution
// - data reads and writes run back to back without idle cycles
// - each channel operation takes at least two bus cycles
// - channel cycles use ordinary read and write timing
// - channel word transfer is indivisible; no data or prefetch inside it
// - channel transfers are always words
// - odd channel memory address splits into two bytes, three cycles total
// - prefetch requested when two or more queue bytes are empty
// - odd control-transfer target gives one byte fetch, else word fetches
// - prefetch stops once a control transfer or halt is queued
package cbrs_pkg;
	localparam int          ADDR_W       = 24;
	localparam int          QUEUE_BYTES  = 6;
	localparam int          PF_MIN_FREE  = 2;
	localparam int          PF_INHIBIT   = 2;
	localparam logic [7:0]  GP_FAULT_VEC = 8'h0d;

	// bus cycle kinds driven with each started cycle
	typedef enum logic [2:0] {
		CBRS_K_READ  = 3'h0,
		CBRS_K_WRITE = 3'h1,
		CBRS_K_CPRD  = 3'h2,
		CBRS_K_CPWR  = 3'h3,
		CBRS_K_FETCH = 3'h4
	} cbrs_kind_t;

	// requester codes, one-hot in priority order
	typedef enum logic [6:0] {
		CBRS_G_NONE  = 7'h00,
		CBRS_G_LOCK  = 7'h01,
		CBRS_G_SPLIT = 7'h02,
		CBRS_G_HOLD  = 7'h04,
		CBRS_G_CP    = 7'h08,
		CBRS_G_EXEC  = 7'h10,
		CBRS_G_WBUF  = 7'h20,
		CBRS_G_PF    = 7'h40
	} cbrs_grant_t;

	// sequencer states
	typedef enum logic [3:0] {
		CBRS_S_IDLE = 4'h1,
		CBRS_S_BUSY = 4'h2,
		CBRS_S_HOLD = 4'h4,
		CBRS_S_CHAN = 4'h8
	} cbrs_state_t;
endpackage

/* rtl/cbrs_prio.sv */
// fixed-priority picker across bus requesters
`timescale 1ns/10ps
module cbrs_prio #(
	parameter int N = 7
) (
	// requests, bit 0 highest
	input  wire logic [N-1:0] req_i,
	// one-hot grant
	output logic      [N-1:0] gnt_o
);
	initial begin
		if (N < 2) $error("cbrs_prio needs at least two requesters");
	end

	// lowest set bit wins; all others wait
	always_comb begin
		gnt_o = req_i & (~req_i + {{(N-1){1'b0}}, 1'b1});
	end
endmodule

/* rtl/cbrs_fetch_limit.sv */
// prefetch address generator with code segment limit handling
`timescale 1ns/10ps
module cbrs_fetch_limit #(
	parameter int AW = cbrs_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          ce_i,
	// control transfer and fetch progress
	input  wire logic          jump_i,
	input  wire logic [AW-1:0] jump_addr_i,
	input  wire logic          prot_mode_i,
	input  wire logic [AW-1:0] seg_last_i,
	input  wire logic          fetch_done_i,
	// next fetch
	output logic      [AW-1:0] fetch_addr_o,
	output logic               fetch_byte_o,
	output logic               at_limit_o
);
	logic [AW-1:0] addr_ff;
	logic [AW-1:0] nxt_addr;

	initial begin
		if (AW < 2) $error("cbrs_fetch_limit address too narrow");
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_ff <= '0;
		end else if (ce_i) begin
			if (jump_i) begin
				addr_ff <= jump_addr_i;
			end else if (fetch_done_i) begin
				addr_ff <= nxt_addr;
			end
		end
	end

	// a fetch ending now hands its successor to a start in the same cycle
	always_comb begin
		nxt_addr = addr_ff;
		if (fetch_done_i) begin
			// odd start is one byte, then aligned words
			nxt_addr = {addr_ff[AW-1:1] + {{(AW-2){1'b0}}, 1'b1}, 1'b0};
		end
	end

	assign fetch_addr_o = nxt_addr;
	assign fetch_byte_o = nxt_addr[0];
	// word holding the last byte is the final fetch, even byte included
	assign at_limit_o   = prot_mode_i && (nxt_addr[AW-1:1] > seg_last_i[AW-1:1]);
endmodule

/* bench/cbrs_bus_model.sv */
// local bus partner model: ends every started cycle after a chosen wait
`timescale 1ns/10ps
module cbrs_bus_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// cycle start and wait states
	input  wire logic       cyc_start_i,
	input  wire logic [3:0] wait_i,
	// end of cycle
	output logic            bus_done_o
);
	logic       busy_ff;
	logic [3:0] cnt_ff;
	// channel cycles get the same wait handling as plain reads and writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			bus_done_o <= 1'b0;
		end else begin
			bus_done_o <= busy_ff && (cnt_ff == 4'h0) && !cyc_start_i;
			if (cyc_start_i) begin
				busy_ff <= 1'b1;
				cnt_ff <= wait_i;
			end else if (busy_ff && cnt_ff == 4'h0) begin
				busy_ff <= 1'b0;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule

/* bench/cpu_bus_request_scheduler_tb_top.sv */
// self-checking bench for the bus request scheduler
`timescale 1ns/10ps
module cpu_bus_request_scheduler_tb_top;
	typedef struct {
		logic req, wr, lock, word;
		logic [23:0] addr;
		logic cp, cpm;
		logic [2:0] qf;
		int n;
		logic [2:0] k;
		logic b;
	} cbrs_row_t;
	logic clk_i = 0, rst_n_i = 0, ce_i = 1;
	logic exec_req_i = 0, exec_wr_i = 0, exec_lock_i = 0, exec_pre_i = 0, exec_word_i = 0;
	logic [23:0] exec_addr_i = 0, jump_addr_i = 0, seg_last_i = 0, exec_ip_i = 0;
	logic [23:0] instr_end_i = 0, cp_addr_i = 0;
	logic [15:0] exec_wdata_i = 0;
	logic [2:0] queue_free_i = 0;
	logic flow_stop_i = 0, jump_i = 0, prot_mode_i = 0, hold_i = 0;
	logic coproc_xfer_request_i = 0, cp_to_mem_i = 0;
	logic [3:0] wait_st = 0;
	logic exec_ack_o, exec_stall_o, gp_fault_o, hold_ack_o, bus_done_i;
	logic cyc_start_o, cyc_byte_o, cyc_lock_o;
	logic [7:0] fault_vec_o;
	logic [2:0] cyc_kind_o;
	logic [23:0] cyc_addr_o;
	logic [15:0] cyc_wdata_o;
	logic [2:0] kq[$];
	logic [23:0] aq[$];
	logic bq[$], lq[$];
	logic [15:0] wq[$];
	int tq[$];
	int cyc = 0, err_total = 0, cmp_count = 0;
	cbrs_row_t rows[9];
	cbrs_row_t r;

	always #2.5 clk_i = ~clk_i;

	cbrs_sched i_cbrs_sched (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.exec_req_i(exec_req_i), .exec_wr_i(exec_wr_i), .exec_lock_i(exec_lock_i),
		.exec_pre_i(exec_pre_i), .exec_addr_i(exec_addr_i), .exec_wdata_i(exec_wdata_i),
		.exec_word_i(exec_word_i), .exec_ack_o(exec_ack_o), .exec_stall_o(exec_stall_o),
		.queue_free_i(queue_free_i), .flow_stop_i(flow_stop_i), .jump_i(jump_i),
		.jump_addr_i(jump_addr_i), .prot_mode_i(prot_mode_i), .seg_last_i(seg_last_i),
		.exec_ip_i(exec_ip_i), .instr_end_i(instr_end_i), .gp_fault_o(gp_fault_o),
		.fault_vec_o(fault_vec_o), .coproc_xfer_request_i(coproc_xfer_request_i),
		.cp_to_mem_i(cp_to_mem_i), .cp_addr_i(cp_addr_i), .hold_i(hold_i),
		.hold_ack_o(hold_ack_o), .bus_done_i(bus_done_i), .cyc_start_o(cyc_start_o),
		.cyc_kind_o(cyc_kind_o), .cyc_addr_o(cyc_addr_o), .cyc_wdata_o(cyc_wdata_o),
		.cyc_byte_o(cyc_byte_o), .cyc_lock_o(cyc_lock_o)
	);

	cbrs_bus_model i_cbrs_bus_model (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_start_i(cyc_start_o),
		.wait_i(wait_st), .bus_done_o(bus_done_i)
	);

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// started cycles are logged with the clock count at which they stood
	always @(posedge clk_i) begin
		if (cyc_start_o === 1'b1) begin
			kq.push_back(cyc_kind_o);
			aq.push_back(cyc_addr_o);
			bq.push_back(cyc_byte_o);
			lq.push_back(cyc_lock_o);
			wq.push_back(cyc_wdata_o);
			tq.push_back(cyc);
			if (cyc_kind_o == cbrs_pkg::CBRS_K_CPRD || cyc_kind_o == cbrs_pkg::CBRS_K_CPWR)
				chk("channel byte flag", 0, cyc_byte_o);
			if (prot_mode_i && cyc_kind_o == cbrs_pkg::CBRS_K_FETCH)
				chk("fetch past limit", 1, cyc_addr_o <= seg_last_i);
		end
		cyc = cyc + 1;
	end

	task automatic tick(int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic clr;
		kq.delete(); aq.delete(); bq.delete(); lq.delete(); wq.delete(); tq.delete();
	endtask

	// ack stands only in the taking cycle, so it is looked at just after the falling edge
	task automatic wait_ack(bit keep = 0);
		int i;
		for (i = 0; i < 200; i++) begin
			#1;
			if (exec_ack_o === 1'b1) break;
			@(negedge clk_i);
		end
		if (i == 200) begin
			chk("ack timeout", 1, 0);
			complete_run();
		end
		@(negedge clk_i);
		if (!keep) exec_req_i = 0;
	endtask

	task automatic wait_starts(int n);
		int i;
		for (i = 0; i < 200 && kq.size() < n; i++) @(negedge clk_i);
		if (kq.size() < n) begin
			chk("start timeout", n, kq.size());
			complete_run();
		end
	endtask

	task automatic exec(logic wr, logic [23:0] a, logic [15:0] d);
		exec_req_i = 1;
		exec_wr_i = wr;
		exec_lock_i = 0;
		exec_word_i = 1;
		exec_addr_i = a;
		exec_wdata_i = d;
	endtask

	initial begin
		rows = '{
			'{1, 0, 0, 1, 24'h000100, 0, 0, 0, 1, 3'h0, 0},
			'{1, 1, 0, 1, 24'h000200, 0, 0, 0, 1, 3'h1, 0},
			'{1, 0, 1, 1, 24'h000300, 0, 0, 0, 1, 3'h0, 0},
			'{1, 0, 0, 1, 24'h000401, 0, 0, 0, 2, 3'h0, 1},
			'{1, 0, 0, 0, 24'h000403, 0, 0, 0, 1, 3'h0, 1},
			'{0, 0, 0, 0, 24'h000500, 1, 0, 0, 2, 3'h7, 0},
			'{0, 0, 0, 0, 24'h000501, 1, 1, 0, 3, 3'h7, 0},
			'{0, 0, 0, 0, 24'h000000, 0, 0, 2, 1, 3'h4, 0},
			'{0, 0, 0, 0, 24'h000000, 0, 0, 1, 0, 3'h7, 0}};
		tick(8);
		chk("start in reset", 0, cyc_start_o);
		chk("hold ack in reset", 0, hold_ack_o);
		chk("fault in reset", 0, gp_fault_o);
		rst_n_i = 1;
		for (int i = 0; i < 9; i++) begin
			r = rows[i];
			tick(1);
			clr();
			exec_req_i = r.req; exec_wr_i = r.wr; exec_lock_i = r.lock;
			exec_word_i = r.word; exec_addr_i = r.addr;
			coproc_xfer_request_i = r.cp; cp_to_mem_i = r.cpm; cp_addr_i = r.addr;
			queue_free_i = r.qf;
			if (r.req) wait_ack();
			if (r.n > 0) wait_starts(r.n);
			coproc_xfer_request_i = 0;
			queue_free_i = 0;
			tick(12);
			chk("cycle count", r.n, kq.size());
			if (r.n > 0 && r.k != 3'h7) chk("kind", r.k, kq[0]);
			if (r.n > 0 && r.k != 3'h7) chk("byte", r.b, bq[0]);
			if (r.req) chk("lock", r.lock, lq[0]);
			if (r.n == 2 && r.req) chk("second half", r.addr + 24'h1, aq[1]);
			if (r.cpm) chk("channel first byte", r.addr, aq[1]);
			if (r.cpm) chk("channel second byte", r.addr + 24'h1, aq[2]);
			$display("row %0d done", i);
		end
		// hold wins over a waiting data request
		clr();
		hold_i = 1;
		exec(0, 24'h000600, 16'h0);
		tick(3);
		#1;
		chk("hold ack", 1, hold_ack_o);
		chk("exec ack under hold", 0, exec_ack_o);
		tick(1);
		hold_i = 0;
		wait_ack();
		wait_starts(1);
		chk("after hold", 24'h000600, aq[0]);
		$display("hold test done");
		// channel beats data and is not split by it
		tick(4);
		clr();
		coproc_xfer_request_i = 1; cp_to_mem_i = 0; cp_addr_i = 24'h000700;
		exec(0, 24'h000800, 16'h0);
		wait_starts(2);
		coproc_xfer_request_i = 0;
		wait_ack();
		wait_starts(3);
		chk("channel first", 24'h000700, aq[0]);
		chk("data after channel", 24'h000800, aq[2]);
		$display("channel test done");
		// single write buffer in front of a slow read
		tick(8);
		clr();
		wait_st = 6;
		exec(0, 24'h000900, 16'h0);
		wait_ack(1);
		exec(1, 24'h000a00, 16'h1234);
		wait_ack(1);
		chk("write taken while busy", 1, kq.size());
		exec(1, 24'h000a10, 16'h5678);
		#1;
		chk("stall", 1, exec_stall_o);
		chk("ack while full", 0, exec_ack_o);
		wait_ack();
		wait_starts(3);
		chk("buffered addr", 24'h000a00, aq[1]);
		chk("buffered data", 16'h1234, wq[1]);
		chk("gap", 9, tq[2] - tq[1]);
		$display("write buffer test done");
		// announced data transfer keeps prefetch off
		tick(30);
		clr();
		wait_st = 0;
		queue_free_i = 6;
		exec_pre_i = 1;
		tick(1);
		exec_pre_i = 0;
		tick(1);
		exec(0, 24'h000b00, 16'h0);
		wait_ack();
		wait_starts(1);
		chk("no fetch first", cbrs_pkg::CBRS_K_READ, kq[0]);
		// a started prefetch runs to its end
		tick(10);
		clr();
		wait_st = 4;
		wait_starts(1);
		exec(0, 24'h000c00, 16'h0);
		wait_ack();
		queue_free_i = 0;
		wait_starts(2);
		chk("read after fetch", 24'h000c00, aq[1]);
		chk("fetch gap", 7, tq[1] - tq[0]);
		$display("prefetch tests done");
		// protected limit with odd target and even last byte
		tick(20);
		wait_st = 0;
		prot_mode_i = 1; seg_last_i = 24'h000104; jump_addr_i = 24'h000101; jump_i = 1;
		tick(1);
		jump_i = 0;
		clr();
		queue_free_i = 6;
		wait_starts(3);
		tick(20);
		chk("fetches to limit", 3, kq.size());
		chk("odd target byte", 1, bq[0]);
		chk("odd target addr", 24'h000101, aq[0]);
		chk("last fetch addr", 24'h000104, aq[2]);
		chk("last fetch word", 0, bq[2]);
		exec_ip_i = 24'h000110; instr_end_i = 24'h00010f;
		tick(3);
		chk("fault", 1, gp_fault_o);
		chk("fault vector", 8'h0d, fault_vec_o);
		// queued jump stops fetching
		prot_mode_i = 0; exec_ip_i = 0; instr_end_i = 0;
		jump_addr_i = 24'h000200; jump_i = 1;
		tick(1);
		jump_i = 0;
		flow_stop_i = 1;
		tick(1);
		clr();
		flow_stop_i = 0;
		tick(20);
		chk("fetch after stop", 0, kq.size());
		$display("limit tests done");
		// a low enable freezes a waiting request
		clr();
		ce_i = 0;
		exec(0, 24'h000d00, 16'h0);
		tick(4);
		chk("ack while frozen", 0, exec_ack_o);
		chk("start while frozen", 0, kq.size());
		ce_i = 1;
		wait_ack();
		wait_starts(1);
		chk("start after enable", 24'h000d00, aq[0]);
		$display("enable test done");
		complete_run();
	end
endmodule
